// ==== verilog/ptr_flags_pkg.sv ====
// Shared constants and types for the indirect pointer and condition flag block
package ptr_flags_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_PTR = 3;
  localparam int NUM_MODES = 5;

  // Register byte offsets on the register bus
  localparam logic [11:0] OFS_PTR_BASE = 12'h000;
  localparam logic [11:0] OFS_FLAGS = 12'h00c;
  localparam logic [11:0] OFS_ACC = 12'h010;
  localparam logic [11:0] OFS_ALU_CMD = 12'h014;
  localparam logic [11:0] OFS_PORT_BASE = 12'h040;
  localparam logic [11:0] OFS_PORT_SPAN = 12'h060;

  // Field positions
  localparam int PTR_LOW_LSB = 0;
  localparam int PTR_UP_LSB = 8;
  localparam int ALU_OPND_LSB = 0;
  localparam int ALU_OP_LSB = 8;
  localparam int ALU_DEST_BIT = 12;
  localparam int FLAG_W = 5;

  // Reset values
  localparam logic [11:0] PTR_RST = 12'h000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;

  typedef enum logic [2:0] {
    MODE_PLAIN = 3'h0,
    MODE_DOWN_AFTER = 3'h1,
    MODE_UP_AFTER = 3'h2,
    MODE_UP_BEFORE = 3'h3,
    MODE_OFFSET = 3'h4
  } ptr_mode_e;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUB = 4'h1,
    OP_AND = 4'h2,
    OP_IOR = 4'h3,
    OP_XOR = 4'h4,
    OP_RLC = 4'h5,
    OP_RRC = 4'h6,
    OP_MOV = 4'h7,
    OP_CLR = 4'h8,
    OP_SWAP = 4'h9
  } alu_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } bus_state_e;

  // Bit 4 down to bit 0 of the flag register
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } flags_s;

endpackage

// ==== verilog/alu_flag_unit.sv ====
// Byte ALU that produces a result and the five condition flags
`timescale 1ns/1ps
`default_nettype none
module alu_flag_unit import ptr_flags_pkg::*; (
  input wire alu_op_e op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire flags_s flags_in,
  output logic [7:0] result_out,
  output flags_s flags_out,
  output logic writes_flags_out
);

  always_comb begin
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] opb;
    logic cin;
    // Subtract adds the two's complement, carries act as inverted borrow
    opb = (op_in == OP_SUB) ? ~b_in : b_in;
    cin = (op_in == OP_SUB);
    sum = {1'b0, a_in} + {1'b0, opb} + {8'h00, cin};
    low = {1'b0, a_in[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    result_out = 8'h00;
    flags_out = flags_in;
    writes_flags_out = 1'b1;
    case (op_in)
      OP_ADD, OP_SUB: begin
        result_out = sum[7:0];
        flags_out.c = sum[8];
        flags_out.dc = low[4];
        flags_out.ov = (a_in[7] == opb[7]) && (sum[7] != a_in[7]);
      end
      OP_AND: result_out = a_in & b_in;
      OP_IOR: result_out = a_in | b_in;
      OP_XOR: result_out = a_in ^ b_in;
      OP_RLC: begin
        result_out = {a_in[6:0], flags_in.c};
        flags_out.c = a_in[7];
        flags_out.dc = a_in[3];
      end
      OP_RRC: begin
        result_out = {flags_in.c, a_in[7:1]};
        flags_out.c = a_in[0];
        flags_out.dc = a_in[4];
      end
      OP_MOV: begin
        result_out = b_in;
        writes_flags_out = 1'b0;
      end
      OP_SWAP: begin
        result_out = {b_in[3:0], b_in[7:4]};
        writes_flags_out = 1'b0;
      end
      OP_CLR: result_out = 8'h00;
      default: writes_flags_out = 1'b0;
    endcase
    if (writes_flags_out) begin
      flags_out.z = (result_out == 8'h00);
      flags_out.n = result_out[7];
    end
  end

endmodule // alu_flag_unit
`default_nettype wire

// ==== verilog/indirect_pointer_and_alu_flags.sv ====
// Three data memory pointers with access ports, data memory and the ALU flag register
// Summary of operation
// - Three pointers, each 12 bits from a low byte and an upper nibble.
// - An access port reads or writes the memory byte its pointer selects.
// - Indirect read of an access port returns zero and sets the zero flag.
// - Indirect write of an access port does nothing; flags stay unchanged.
// - Five ports per pointer: plain, down after, up after, up before, offset.
// - Down-after port uses the pointer, then decrements it.
// - Up-after port uses the pointer, then increments it.
// - Up-before port increments the pointer, then uses the new value.
// - Offset port addresses pointer plus signed accumulator; neither changes.
// - Increment and decrement carry across all twelve pointer bits.
// - Pointer stepping never touches the condition flags.
// - ALU result aimed at the flag register loads the five flags only for move, swap and unknown ops.
// - Flag bits 7 to 5 read as zero.
// - Negative flag copies result bit 7.
// - Overflow flag marks a signed overflow that flips the sign bit.
// - Zero flag marks a zero result.
// - Digit carry is the carry out of result bit 3 for add and subtract.
// - Carry is the carry out of result bit 7 for add and subtract.
// - Subtract adds the two's complement, so carries are inverted borrows.
// - Rotates load digit carry from source bit 3 or bit 4.
// - Rotates load carry from source bit 7 or bit 0 by direction.
// - Unimplemented banks read zero and drop writes.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module indirect_pointer_and_alu_flags import ptr_flags_pkg::*; #(
  parameter int IMPL_BANKS = 2,
  parameter logic [11:0] MEM_PORT_BASE = 12'hfe0
) (
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [7:0] FLAGS_OUT,
  output logic [7:0] ACC_OUT
);

  localparam int MEM_DEPTH = IMPL_BANKS * 256;

  bus_state_e state_q;
  logic [11:0] ptr_q [NUM_PTR];
  logic [7:0] acc_q;
  flags_s flags_q;
  logic [7:0] mem_q [MEM_DEPTH];
  logic [31:0] prdata_q;
  logic slverr_q;

  logic hit_ptr, hit_flags, hit_acc, hit_alu, hit_port, mapped;
  logic [11:0] port_off;
  logic [1:0] port_ptr, reg_ptr;
  ptr_mode_e port_mode;
  logic [11:0] cur_ptr, eff_addr;
  logic tgt_port, tgt_impl;
  logic [7:0] ind_rdata;
  logic done_xfer, done_port, done_rd, done_wr;
  logic [7:0] alu_result;
  flags_s alu_flags;
  logic alu_writes_flags;

  // Address decode
  always_comb begin
    port_off = PADDR_IN - OFS_PORT_BASE;
    hit_ptr = (PADDR_IN < OFS_FLAGS) && (PADDR_IN[1:0] == 2'b00);
    hit_flags = (PADDR_IN == OFS_FLAGS);
    hit_acc = (PADDR_IN == OFS_ACC);
    hit_alu = (PADDR_IN == OFS_ALU_CMD);
    hit_port = (PADDR_IN >= OFS_PORT_BASE) && (port_off < OFS_PORT_SPAN)
               && (port_off[1:0] == 2'b00) && (port_off[4:2] < 3'(NUM_MODES));
    mapped = hit_ptr || hit_flags || hit_acc || hit_alu || hit_port;
    reg_ptr = hit_ptr ? PADDR_IN[3:2] : 2'd0;
    port_ptr = hit_port ? port_off[6:5] : 2'd0;
    port_mode = hit_port ? ptr_mode_e'(port_off[4:2]) : MODE_PLAIN;
  end

  // Effective data memory address of an access port
  always_comb begin
    cur_ptr = ptr_q[port_ptr];
    case (port_mode)
      MODE_UP_BEFORE: eff_addr = cur_ptr + 12'h001;
      MODE_OFFSET: eff_addr = cur_ptr + {{4{acc_q[7]}}, acc_q};
      default: eff_addr = cur_ptr;
    endcase
    tgt_port = (eff_addr >= MEM_PORT_BASE)
               && ((eff_addr - MEM_PORT_BASE) < 12'(NUM_PTR * NUM_MODES));
    tgt_impl = (int'(eff_addr[11:8]) < IMPL_BANKS);
    if (tgt_port || !tgt_impl) begin
      ind_rdata = 8'h00;
    end else begin
      ind_rdata = mem_q[eff_addr[$clog2(MEM_DEPTH)-1:0]];
    end
  end

  assign done_xfer = (state_q == ST_DONE) && PSEL_IN && PENABLE_IN;
  assign done_port = done_xfer && hit_port;
  assign done_rd = done_xfer && !PWRITE_IN;
  assign done_wr = done_xfer && PWRITE_IN;

  alu_flag_unit u_alu (
    .op_in(alu_op_e'(PWDATA_IN[ALU_OP_LSB +: 4])),
    .a_in(acc_q),
    .b_in(PWDATA_IN[ALU_OPND_LSB +: 8]),
    .flags_in(flags_q),
    .result_out(alu_result),
    .flags_out(alu_flags),
    .writes_flags_out(alu_writes_flags)
  );

  // Bus phase: one wait cycle, answer on the following edge
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: state_q <= (PSEL_IN && PENABLE_IN) ? ST_WAIT : ST_IDLE;
        ST_WAIT: state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Read data and error answer, captured during the wait cycle
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (state_q == ST_WAIT) begin
      slverr_q <= !mapped;
      if (hit_ptr) begin
        prdata_q <= {20'h00000, ptr_q[reg_ptr]};
      end else if (hit_flags) begin
        prdata_q <= {24'h000000, 3'b000, flags_q};
      end else if (hit_acc) begin
        prdata_q <= {24'h000000, acc_q};
      end else if (hit_port && !PWRITE_IN) begin
        prdata_q <= {24'h000000, ind_rdata};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Pointer update per entry
  for (genvar gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
    always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
        ptr_q[gi] <= PTR_RST;
      end else if (done_wr && hit_ptr && reg_ptr == 2'(gi)) begin
        ptr_q[gi] <= {PWDATA_IN[PTR_UP_LSB +: 4], PWDATA_IN[PTR_LOW_LSB +: 8]};
      end else if (done_port && port_ptr == 2'(gi)) begin
        case (port_mode)
          MODE_DOWN_AFTER: ptr_q[gi] <= cur_ptr - 12'h001;
          MODE_UP_AFTER: ptr_q[gi] <= cur_ptr + 12'h001;
          MODE_UP_BEFORE: ptr_q[gi] <= cur_ptr + 12'h001;
          default: ptr_q[gi] <= ptr_q[gi];
        endcase
      end
    end
  end

  // Accumulator
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      acc_q <= ACC_RST;
    end else if (done_wr && hit_acc) begin
      acc_q <= PWDATA_IN[7:0];
    end else if (done_wr && hit_alu && !PWDATA_IN[ALU_DEST_BIT]) begin
      acc_q <= alu_result;
    end
  end

  // Condition flags
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      flags_q <= FLAGS_RST;
    end else if (done_wr && hit_flags) begin
      flags_q <= PWDATA_IN[FLAG_W-1:0];
    end else if (done_wr && hit_alu) begin
      if (alu_writes_flags) begin
        flags_q <= alu_flags;
      end else if (PWDATA_IN[ALU_DEST_BIT]) begin
        flags_q <= alu_result[FLAG_W-1:0];
      end
    end else if (done_rd && hit_port && tgt_port) begin
      flags_q.z <= 1'b1;
    end
  end

  // Data memory, writes to ports or absent banks are dropped
  always_ff @(posedge SYS_CLK_IN) begin
    if (done_wr && hit_port && !tgt_port && tgt_impl) begin
      mem_q[eff_addr[$clog2(MEM_DEPTH)-1:0]] <= PWDATA_IN[7:0];
    end
  end

  assign PREADY_OUT = (state_q == ST_DONE);
  assign PRDATA_OUT = prdata_q;
  assign PSLVERR_OUT = (state_q == ST_DONE) && slverr_q;
  assign FLAGS_OUT = {3'b000, flags_q};
  assign ACC_OUT = acc_q;

  // Checking helpers
  logic chk_q;
  logic [1:0] chk_sel_q;
  ptr_mode_e chk_mode_q;
  logic [11:0] chk_old_q;
  logic [7:0] chk_acc_q;
  logic [11:0] chk_eff_q;
  localparam int MEM_AW = $clog2(MEM_DEPTH);
  logic alu_add, alu_sub, alu_rlc, alu_flag_wr;
  assign alu_add = done_wr && hit_alu && (PWDATA_IN[ALU_OP_LSB +: 4] == OP_ADD);
  assign alu_sub = done_wr && hit_alu && (PWDATA_IN[ALU_OP_LSB +: 4] == OP_SUB);
  assign alu_rlc = done_wr && hit_alu && (PWDATA_IN[ALU_OP_LSB +: 4] == OP_RLC);
  assign alu_flag_wr = done_wr && hit_alu && alu_writes_flags;
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      chk_q <= 1'b0;
      chk_sel_q <= 2'd0;
      chk_mode_q <= MODE_PLAIN;
      chk_old_q <= 12'h000;
      chk_acc_q <= 8'h00;
      chk_eff_q <= 12'h000;
    end else begin
      chk_q <= done_port;
      chk_sel_q <= port_ptr;
      chk_mode_q <= port_mode;
      chk_old_q <= cur_ptr;
      chk_acc_q <= acc_q;
      chk_eff_q <= eff_addr;
    end
  end

  a_port_read_zero: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    done_rd && hit_port && tgt_port |-> PRDATA_OUT == 32'h0 ##1 flags_q.z)
    else $error("port read not zero or zero flag clear");
  a_port_write_nop: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    done_wr && hit_port && tgt_port |=> $stable(flags_q))
    else $error("port write changed flags");
  a_down_after: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    chk_q && chk_mode_q == MODE_DOWN_AFTER |-> ptr_q[chk_sel_q] == chk_old_q - 12'h001)
    else $error("down-after pointer wrong");
  a_up_after: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    chk_q && chk_mode_q == MODE_UP_AFTER |-> ptr_q[chk_sel_q] == chk_old_q + 12'h001)
    else $error("up-after pointer wrong");
  a_up_before: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    chk_q && chk_mode_q == MODE_UP_BEFORE
    |-> ptr_q[chk_sel_q] == chk_old_q + 12'h001 && chk_eff_q == ptr_q[chk_sel_q])
    else $error("up-before address wrong");
  a_offset_keeps: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    chk_q && chk_mode_q == MODE_OFFSET |-> ptr_q[chk_sel_q] == chk_old_q && acc_q == chk_acc_q)
    else $error("offset access changed pointer or accumulator");
  a_flags_upper: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    PREADY_OUT && hit_flags && !PWRITE_IN |-> PRDATA_OUT[7:5] == 3'b000 && FLAGS_OUT[7:5] == 3'b000)
    else $error("flag upper bits not zero");
  a_absent_bank: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    done_rd && hit_port && !tgt_port && !tgt_impl |-> PRDATA_OUT == 32'h0)
    else $error("absent bank read not zero");
  a_alu_to_flags: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    done_wr && hit_alu && alu_writes_flags && PWDATA_IN[ALU_DEST_BIT]
    |=> flags_q == $past(alu_flags))
    else $error("flag destination overrode computed flags");

  // Register and memory landing, plain access pointer hold, flags kept on port access
  a_ptr_load: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    done_wr && hit_ptr
    |=> ptr_q[$past(reg_ptr)] == $past(PWDATA_IN[11:0]))
    else $error("pointer load wrong");
  a_port_wdata: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    done_wr && hit_port && !tgt_port && tgt_impl
    |=> mem_q[$past(eff_addr[MEM_AW-1:0])] == $past(PWDATA_IN[7:0]))
    else $error("port write did not land");
  a_plain_keeps: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    chk_q && chk_mode_q == MODE_PLAIN
    |-> ptr_q[chk_sel_q] == chk_old_q)
    else $error("plain access changed pointer");
  a_step_no_flags: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    done_port && !(done_rd && tgt_port)
    |=> $stable(flags_q))
    else $error("pointer access changed flags");

  // Flag results of the ALU
  a_alu_sign: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    alu_flag_wr
    |=> flags_q.n == $past(alu_result[7]))
    else $error("negative flag wrong");
  a_alu_zero: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    alu_flag_wr
    |=> flags_q.z == ($past(alu_result) == 8'h00))
    else $error("zero flag wrong");
  a_add_carry: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    alu_add
    |=> flags_q.c == ($past(acc_q) > ~$past(PWDATA_IN[7:0])))
    else $error("add carry wrong");
  a_add_digit: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    alu_add
    |=> flags_q.dc == ($past(acc_q[3:0]) > ~$past(PWDATA_IN[3:0])))
    else $error("add digit carry wrong");
  a_add_wrap: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    alu_add
    |=> flags_q.ov == ($past(acc_q[7]) == $past(PWDATA_IN[7]) && flags_q.n != $past(acc_q[7])))
    else $error("add overflow wrong");
  a_sub_borrow: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    alu_sub
    |=> flags_q.c == ($past(acc_q) >= $past(PWDATA_IN[7:0])))
    else $error("subtract borrow wrong");
  a_rot_left: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    alu_rlc
    |=> flags_q.c == $past(acc_q[7]) && flags_q.dc == $past(acc_q[3]))
    else $error("rotate left carries wrong");

  // Bus answer
  a_ready_pulse: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    PREADY_OUT
    |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  a_unmapped_err: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
    PREADY_OUT
    |-> PSLVERR_OUT == !mapped)
    else $error("error answer does not match decode");

  c_up_after: cover property (@(posedge SYS_CLK_IN) done_port && port_mode == MODE_UP_AFTER);
  c_offset: cover property (@(posedge SYS_CLK_IN) done_port && port_mode == MODE_OFFSET);
  c_port_read: cover property (@(posedge SYS_CLK_IN) done_rd && hit_port && tgt_port);
  c_alu_sub: cover property (@(posedge SYS_CLK_IN)
    done_wr && hit_alu && PWDATA_IN[ALU_OP_LSB +: 4] == OP_SUB);
  c_flag_dest: cover property (@(posedge SYS_CLK_IN) done_wr && hit_alu && PWDATA_IN[ALU_DEST_BIT]);

endmodule // indirect_pointer_and_alu_flags
`default_nettype wire

// ==== test/indirect_pointer_and_alu_flags_tb_top.sv ====
// Self-checking bench for the indirect pointer and flag block
`timescale 1ns/1ps
`default_nettype none
module indirect_pointer_and_alu_flags_tb_top import ptr_flags_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] flags;
  logic [7:0] acc;
  int errors = 0;
  int checks = 0;

  always #5 clk = ~clk;

  indirect_pointer_and_alu_flags dut (.SYS_CLK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FLAGS_OUT(flags),
    .ACC_OUT(acc));

  task automatic close_out;
    $display("Counts: checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer, held until ready is seen high at a rising edge or 50 rising edges have passed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      $display("ERROR ready expected 1 seen %b", pready);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, exp, r);
  endtask

  function automatic logic [11:0] pa(input int p);
    return OFS_PTR_BASE + 12'(p) * 12'h004;
  endfunction

  function automatic logic [11:0] port(input int p, input ptr_mode_e m);
    return OFS_PORT_BASE + 12'(p) * 12'h020 + 12'(m) * 12'h004;
  endfunction

  function automatic logic [31:0] cmd(input logic dst, input alu_op_e op, input logic [7:0] b);
    return {19'h0, dst, 4'(op), b};
  endfunction

  task automatic t_reset;
    chk("flags pin", 32'h0, {24'h0, flags});
    chk("acc pin", 32'h0, {24'h0, acc});
    for (int p = 0; p < 3; p++) rdc("pointer", pa(p), 32'h0);
    rdc("alu cmd", OFS_ALU_CMD, 32'h0);
    wr(pa(2), 32'hffffffff);
    rdc("pointer width", pa(2), 32'h00000fff);
    wr(OFS_FLAGS, 32'h000000ff);
    rdc("flags upper", OFS_FLAGS, 32'h0000001f);
    wr(OFS_ACC, 32'hffffffff);
    rdc("acc width", OFS_ACC, 32'h000000ff);
    $display("t_reset done");
  endtask

  task automatic t_step;
    wr(OFS_FLAGS, 32'h0);
    wr(pa(1), 32'h0ff);
    wr(port(1, MODE_UP_AFTER), 32'ha5);
    rdc("up after", pa(1), 32'h100);
    wr(port(1, MODE_PLAIN), 32'h5a);
    rdc("plain", pa(1), 32'h100);
    rdc("down data", port(1, MODE_DOWN_AFTER), 32'h5a);
    rdc("down after", pa(1), 32'h0ff);
    rdc("mem", port(1, MODE_PLAIN), 32'ha5);
    wr(pa(2), 32'h0fe);
    rdc("up before data", port(2, MODE_UP_BEFORE), 32'ha5);
    rdc("up before", pa(2), 32'h0ff);
    wr(pa(0), 32'h001);
    wr(port(0, MODE_DOWN_AFTER), 32'h33);
    rdc("to zero", pa(0), 32'h000);
    wr(port(0, MODE_DOWN_AFTER), 32'h00);
    rdc("wrap", pa(0), 32'hfff);
    chk("step flags", 32'h0, {24'h0, flags});
    wr(OFS_ACC, 32'h02);
    rdc("offset wrap", port(0, MODE_OFFSET), 32'h33);
    rdc("offset ptr", pa(0), 32'hfff);
    wr(OFS_ACC, 32'hff);
    wr(port(1, MODE_OFFSET), 32'h77);
    chk("offset acc", 32'hff, {24'h0, acc});
    wr(pa(2), 32'h0fe);
    rdc("offset neg", port(2, MODE_PLAIN), 32'h77);
    $display("t_step done");
  endtask

  task automatic t_special;
    wr(OFS_FLAGS, 32'h0);
    wr(pa(0), 32'hfe0);
    rdc("port read", port(0, MODE_UP_AFTER), 32'h0);
    chk("port read z", 32'h04, {24'h0, flags});
    wr(OFS_FLAGS, 32'h1b);
    wr(pa(1), 32'h1ee);
    wr(port(1, MODE_PLAIN), 32'h11);
    wr(pa(0), 32'hfee);
    wr(port(0, MODE_PLAIN), 32'h55);
    chk("port write", 32'h1b, {24'h0, flags});
    rdc("port dropped", port(1, MODE_PLAIN), 32'h11);
    rdc("port stays", port(0, MODE_PLAIN), 32'h0);
    wr(pa(0), 32'h200);
    wr(port(0, MODE_PLAIN), 32'h99);
    rdc("absent bank", port(0, MODE_PLAIN), 32'h0);
    wr(pa(1), 32'h000);
    rdc("absent alias", port(1, MODE_PLAIN), 32'h0);
    $display("t_special done");
  endtask

  task automatic t_alu;
    logic [7:0] va[5] = '{8'h7f, 8'hff, 8'h00, 8'h80, 8'h05};
    logic [7:0] vb[5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h05};
    logic vs[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [7:0] vr[5] = '{8'h80, 8'h00, 8'hff, 8'h7f, 8'h00};
    logic [7:0] vf[5] = '{8'h1a, 8'h07, 8'h10, 8'h09, 8'h07};
    alu_op_e lop[3] = '{OP_AND, OP_IOR, OP_XOR};
    logic [7:0] lres[3] = '{8'h00, 8'hff, 8'hff};
    logic [7:0] lflg[3] = '{8'h0f, 8'h1b, 8'h1b};
    for (int i = 0; i < 5; i++) begin
      wr(OFS_ACC, {24'h0, va[i]});
      wr(OFS_ALU_CMD, cmd(1'b0, vs[i] ? OP_SUB : OP_ADD, vb[i]));
      rdc("sum", OFS_ACC, {24'h0, vr[i]});
      chk("arith flags", {24'h0, vf[i]}, {24'h0, flags});
    end
    for (int i = 0; i < 3; i++) begin
      wr(OFS_FLAGS, 32'h0b);
      wr(OFS_ACC, 32'hf0);
      wr(OFS_ALU_CMD, cmd(1'b0, lop[i], 8'h0f));
      chk("logic acc", {24'h0, lres[i]}, {24'h0, acc});
      chk("logic flags", {24'h0, lflg[i]}, {24'h0, flags});
    end
    wr(OFS_FLAGS, 32'h00);
    wr(OFS_ACC, 32'h88);
    wr(OFS_ALU_CMD, cmd(1'b0, OP_RLC, 8'h00));
    chk("rotl acc", 32'h10, {24'h0, acc});
    chk("rotl flags", 32'h03, {24'h0, flags});
    wr(OFS_FLAGS, 32'h01);
    wr(OFS_ACC, 32'h11);
    wr(OFS_ALU_CMD, cmd(1'b0, OP_RRC, 8'h00));
    chk("rotr acc", 32'h88, {24'h0, acc});
    chk("rotr flags", 32'h13, {24'h0, flags});
    wr(OFS_ALU_CMD, cmd(1'b0, OP_SWAP, 8'h3c));
    chk("swap acc", 32'hc3, {24'h0, acc});
    wr(OFS_ALU_CMD, cmd(1'b1, OP_MOV, 8'hff));
    rdc("move to flags", OFS_FLAGS, 32'h1f);
    wr(OFS_ALU_CMD, cmd(1'b1, OP_CLR, 8'h00));
    rdc("clear to flags", OFS_FLAGS, 32'h0f);
    chk("dest acc kept", 32'hc3, {24'h0, acc});
    $display("t_alu done");
  endtask

  task automatic t_unmapped;
    logic [11:0] bad[4] = '{12'h018, 12'h0a0, 12'h054, 12'h011};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, bad[i], 32'h5a, r, e);
      chk("refused", 32'h1, {31'h0, e});
      apb(1'b0, bad[i], 32'h0, r, e);
      chk("refused data", 32'h0, r);
    end
    rdc("acc kept", OFS_ACC, 32'hc3);
    wr(OFS_ALU_CMD, cmd(1'b0, alu_op_e'(4'hf), 8'h55));
    chk("unknown op acc", 32'h0, {24'h0, acc});
    chk("unknown op flags", 32'h0f, {24'h0, flags});
    $display("t_unmapped done");
  endtask

  initial begin
    #50000;
    errors++;
    $display("ERROR watchdog expected done seen hang");
    close_out();
  end

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_step();
    t_special();
    t_alu();
    t_unmapped();
    close_out();
  end
endmodule // indirect_pointer_and_alu_flags_tb_top
`default_nettype wire
